/* src/stfs_pkg.sv */
// shared constants and carrier types of the start-up timing supervisor
package stfs_pkg;

  // command codes of the three registers
  localparam logic [7:0] STFS_CMD_RISE_TIME = 8'h61;
  localparam logic [7:0] STFS_CMD_LIMIT = 8'h62;
  localparam logic [7:0] STFS_CMD_RESPONSE = 8'h63;

  // reset values
  localparam logic [6:0] STFS_RISE_RESET = 7'h03;
  localparam logic [6:0] STFS_LIMIT_RESET = 7'h00;
  localparam logic [7:0] STFS_RESPONSE_RESET = 8'hbf;

  // field positions of the response register
  localparam int STFS_IGNORE_BIT = 7;
  localparam int STFS_RETRY_MSB = 5;
  localparam int STFS_RETRY_LSB = 3;
  localparam logic [2:0] STFS_RETRY_NONE = 3'h0;
  localparam logic [2:0] STFS_RETRY_ALWAYS = 3'h7;

  // timing, in milliseconds of the time base except the one limit given in seconds
  localparam logic [6:0] STFS_LOOP_RISE_MS = 7'h64;
  localparam int STFS_SHORT_LIMIT_S = 4;
  localparam logic [12:0] STFS_SHORT_LIMIT_MS =
    13'(STFS_SHORT_LIMIT_S * 1000);
  localparam logic [3:0] STFS_RETRY_RISE_COUNT = 4'h7;
  localparam int STFS_TIMER_W = 13;

  // quantiser bucket bounds and effective times
  localparam int STFS_BUCKETS = 15;
  localparam logic [6:0] STFS_BOUND [STFS_BUCKETS-1] = '{
    7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h09, 7'h0c,
    7'h11, 7'h16, 7'h20, 7'h2c, 7'h3e, 7'h56};
  localparam logic [6:0] STFS_EFFECT [STFS_BUCKETS] = '{
    7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h0a,
    7'h0e, 7'h13, 7'h1b, 7'h25, 7'h34, 7'h48, 7'h64};

  // command request from the bus front end
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } stfs_cmd_t;

  // command answer
  typedef struct packed {
    logic done;
    logic nack;
    logic [15:0] rdata;
  } stfs_rsp_t;

  // sticky status bits
  typedef struct packed {
    logic other_fault;
    logic output_voltage_summary_bit;
    logic startup_timeout_flag;
    logic communication_fault_bit;
    logic invalid_data;
    logic invalid_command_fault;
  } stfs_status_t;

  // supervisor states, gray along idle-ramp-on; ramp and wait differ in two bits
  typedef enum logic [2:0] {
    STFS_IDLE = 3'h0,
    STFS_RAMP = 3'h1,
    STFS_ON = 3'h3,
    STFS_WAIT = 3'h2,
    STFS_HALT = 3'h6
  } stfs_state_t;

endpackage

/* src/stfs_quantize.sv */
// maps a programmed millisecond mantissa onto its effective bucket time
`timescale 1ns/1ps
`default_nettype none
module stfs_quantize
  import stfs_pkg::*;
#(
  parameter bit ZERO_IS_NONE = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [6:0] mant_in,
  output logic [6:0] time_ms_out
);

  logic [6:0] time_d;

  always_comb begin
    time_d = STFS_EFFECT[STFS_BUCKETS-1];
    for (int i = STFS_BUCKETS - 2; i >= 0; i--) begin
      if (mant_in <= STFS_BOUND[i]) begin
        time_d = STFS_EFFECT[i];
      end
    end
    if (ZERO_IS_NONE && mant_in == 7'h00) begin
      time_d = 7'h00;
    end
  end

  // result held in a register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      time_ms_out <= 7'h00;
    end else begin
      time_ms_out <= time_d;
    end
  end

endmodule
`default_nettype wire

/* src/stfs_supervisor.sv */
// start-up timing registers and start-up timeout supervisor
// Functional notes
// - rise-time exponent reads as fixed zero, mantissa counts milliseconds
// - rise-time mantissa upper four bits zero, seven bits writable, reset 3
// - loop follower uses a fixed 100 ms rise time
// - rise mantissa maps to fifteen bucket times, above 86 gives 100
// - timeout timer starts at ramp entry, trips if output stays below UV
// - loop follower: limit/response access NACKed, invalid command, alert
// - start-up limit of zero disables the timeout timer
// - limit shorter than rise: trip four seconds after the rise ends
// - limit register fixed zero exponent and upper bits, resets disabled
// - limit not saved; restore-all sets it back to zero
// - limit zero means no limit, else same fifteen bucket times
// - timeout sets other, vout summary, timeout bits and raises alert unless masked
// - response register saved to nonvolatile copy on store-all
// - default response shuts down and retries after seven rise times
// - response bit 7 resets one, bit 6 reads zero, bits 2-0 read-only
// - ignore mode keeps regulating with flags; act mode shuts down
// - retry 000 stays off until cleared, 111 retries without end
// - retry values other than 000 or 111 rejected with comm fault
// - delay field mirrors bit 5; 111 waits seven rise times
`timescale 1ns/1ps
`default_nettype none
module stfs_supervisor
  import stfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire stfs_cmd_t cmd_in,
  input wire logic loop_follower_in,
  input wire logic power_on_in,
  input wire logic ms_tick_in,
  input wire logic above_uv_in,
  input wire logic timeout_alert_mask_in,
  input wire logic clear_faults_in,
  input wire logic store_all_in,
  input wire logic restore_all_in,
  output stfs_rsp_t rsp_out,
  output stfs_status_t status_out,
  output logic alert_out,
  output logic ramp_active_out,
  output logic output_enable_out,
  output logic [6:0] eff_rise_ms_out
);

  logic [6:0] rise_q;
  logic [6:0] rise_d;
  logic [6:0] limit_q;
  logic [6:0] limit_d;
  logic ignore_or_act_select_q;
  logic ignore_or_act_select_d;
  logic [2:0] retry_setting_q;
  logic [2:0] retry_setting_d;
  logic [6:0] nv_rise_q;
  logic [3:0] nv_resp_q;
  stfs_state_t state_q;
  stfs_state_t state_d;
  logic [STFS_TIMER_W-1:0] cnt_q;
  logic [STFS_TIMER_W-1:0] cnt_d;
  logic tripped_q;
  logic tripped_d;
  stfs_status_t status_d;
  logic alert_d;
  stfs_rsp_t rsp_d;
  logic [6:0] rise_bucket;
  logic [6:0] limit_bucket;

  // quantisers for rise time and limit
  stfs_quantize #(.ZERO_IS_NONE(1'b0)) u_rise_q (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mant_in(rise_q),
    .time_ms_out(rise_bucket)
  );

  stfs_quantize #(.ZERO_IS_NONE(1'b1)) u_limit_q (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mant_in(limit_q),
    .time_ms_out(limit_bucket)
  );

  // command decode
  wire hit_rise = cmd_in.code == STFS_CMD_RISE_TIME;
  wire hit_limit = cmd_in.code == STFS_CMD_LIMIT;
  wire hit_resp = cmd_in.code == STFS_CMD_RESPONSE;
  wire hit_any = hit_rise | hit_limit | hit_resp;
  wire locked = loop_follower_in & hit_any;
  wire [2:0] new_retry = cmd_in.wdata[STFS_RETRY_MSB:STFS_RETRY_LSB];
  wire bad_retry = hit_resp & cmd_in.write &
    (new_retry != STFS_RETRY_NONE) & (new_retry != STFS_RETRY_ALWAYS);
  wire accept = cmd_in.valid & hit_any & ~locked & ~bad_retry;
  wire wr_ok = accept & cmd_in.write;
  wire ivc_event = cmd_in.valid & locked;
  wire cml_event = cmd_in.valid & ~locked & bad_retry;

  // read data assembly
  // bit 6 zero, bits 2-0 follow
  wire [7:0] resp_view = {ignore_or_act_select_q, 1'b0, retry_setting_q,
    {3{retry_setting_q[2]}}};
  wire [15:0] rdata_sel = hit_rise ? {9'h000, rise_q} :
    hit_limit ? {9'h000, limit_q} : {8'h00, resp_view};

  // effective times
  // follower rise time
  wire [6:0] rise_eff = loop_follower_in ? STFS_LOOP_RISE_MS : rise_bucket;
  wire short_limit = limit_bucket < rise_eff;
  wire [STFS_TIMER_W-1:0] deadline = short_limit ?
    STFS_SHORT_LIMIT_MS + STFS_TIMER_W'(rise_eff) :
    STFS_TIMER_W'(limit_bucket);
  // retry wait of seven rise times
  // seven rise times
  // widen both factors first so seven times 100 ms cannot wrap
  wire [STFS_TIMER_W-1:0] retry_wait =
    STFS_TIMER_W'(rise_eff) * STFS_TIMER_W'(STFS_RETRY_RISE_COUNT);
  // trip at deadline while below UV
  wire timeout_hit = (state_q == STFS_RAMP) & (limit_bucket != 7'h00) &
    ~tripped_q & ~above_uv_in & (cnt_q >= deadline);
  wire act = timeout_hit & ignore_or_act_select_q;

  // register writes and restore
  always_comb begin
    rise_d = rise_q;
    limit_d = limit_q;
    ignore_or_act_select_d = ignore_or_act_select_q;
    retry_setting_d = retry_setting_q;
    if (wr_ok && hit_rise) begin
      rise_d = cmd_in.wdata[6:0];
    end
    if (wr_ok && hit_limit) begin
      limit_d = cmd_in.wdata[6:0];
    end
    if (wr_ok && hit_resp) begin
      ignore_or_act_select_d = cmd_in.wdata[STFS_IGNORE_BIT];
      retry_setting_d = new_retry;
    end
    if (restore_all_in) begin
      rise_d = nv_rise_q;
      limit_d = STFS_LIMIT_RESET;
      ignore_or_act_select_d = nv_resp_q[3];
      retry_setting_d = nv_resp_q[2:0];
    end
  end

  // supervisor sequencing
  always_comb begin
    state_d = state_q;
    tripped_d = tripped_q | timeout_hit;
    unique case (state_q)
      STFS_IDLE: begin
        if (power_on_in) begin
          state_d = STFS_RAMP;
        end
      end
      STFS_RAMP: begin
        if (act) begin
          state_d = (retry_setting_q == STFS_RETRY_ALWAYS) ?
            STFS_WAIT : STFS_HALT;
        end else if (above_uv_in) begin
          state_d = STFS_ON;
        end
      end
      STFS_ON: begin
        state_d = STFS_ON;
      end
      STFS_WAIT: begin
        if (cnt_q >= retry_wait) begin
          state_d = STFS_RAMP;
        end
      end
      STFS_HALT: begin
        if (clear_faults_in) begin
          state_d = STFS_IDLE;
        end
      end
      default: begin
        state_d = STFS_IDLE;
      end
    endcase
    if (!power_on_in) begin
      state_d = STFS_IDLE;
    end
    if (state_d == STFS_RAMP && state_q != STFS_RAMP) begin
      tripped_d = 1'b0;
    end
  end

  // millisecond timer restarts on every state change
  always_comb begin
    cnt_d = cnt_q;
    if (state_d != state_q) begin
      cnt_d = '0;
    end else if (ms_tick_in && cnt_q != '1) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // status, set wins over clear
  // timeout status and alert
  always_comb begin
    status_d = clear_faults_in ? '0 : status_out;
    alert_d = clear_faults_in ? 1'b0 : alert_out;
    if (timeout_hit) begin
      status_d.other_fault = 1'b1;
      status_d.output_voltage_summary_bit = 1'b1;
      status_d.startup_timeout_flag = 1'b1;
      alert_d = alert_d | ~timeout_alert_mask_in;
    end
    if (cml_event) begin
      status_d.communication_fault_bit = 1'b1;
      status_d.invalid_data = 1'b1;
      alert_d = 1'b1;
    end
    if (ivc_event) begin
      status_d.invalid_command_fault = 1'b1;
      alert_d = 1'b1;
    end
  end

  // answer to each command, one cycle later
  always_comb begin
    rsp_d.done = cmd_in.valid;
    rsp_d.nack = cmd_in.valid & ~accept;
    rsp_d.rdata = (accept & ~cmd_in.write) ? rdata_sel : 16'h0000;
  end

  // configuration registers
  // ignore bit resets to one
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rise_q <= STFS_RISE_RESET;
      limit_q <= STFS_LIMIT_RESET;
      ignore_or_act_select_q <= STFS_RESPONSE_RESET[STFS_IGNORE_BIT];
      retry_setting_q <= STFS_RESPONSE_RESET[5:3];
    end else begin
      rise_q <= rise_d;
      limit_q <= limit_d;
      ignore_or_act_select_q <= ignore_or_act_select_d;
      retry_setting_q <= retry_setting_d;
    end
  end

  // nonvolatile image
  // store response
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nv_rise_q <= STFS_RISE_RESET;
      nv_resp_q <= {STFS_RESPONSE_RESET[STFS_IGNORE_BIT],
        STFS_RESPONSE_RESET[5:3]};
    end else if (store_all_in) begin
      nv_rise_q <= rise_q;
      nv_resp_q <= {ignore_or_act_select_q, retry_setting_q};
    end
  end

  // state, timer and flags
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= STFS_IDLE;
      cnt_q <= '0;
      tripped_q <= 1'b0;
      status_out <= '0;
      alert_out <= 1'b0;
      rsp_out <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      tripped_q <= tripped_d;
      status_out <= status_d;
      alert_out <= alert_d;
      rsp_out <= rsp_d;
    end
  end

  // registered converter controls
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ramp_active_out <= 1'b0;
      output_enable_out <= 1'b0;
      eff_rise_ms_out <= STFS_RISE_RESET;
    end else begin
      ramp_active_out <= state_d == STFS_RAMP;
      output_enable_out <= (state_d == STFS_RAMP) || (state_d == STFS_ON);
      eff_rise_ms_out <= rise_eff;
    end
  end

endmodule
`default_nettype wire

/* bench/stfs_supervisor_checker.sv */
// port assertions of the start-up timing supervisor
`timescale 1ns/1ps
`default_nettype none
module stfs_supervisor_checker
  import stfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire stfs_cmd_t cmd_in,
  input wire logic loop_follower_in,
  input wire logic timeout_alert_mask_in,
  input wire stfs_rsp_t rsp_out,
  input wire stfs_status_t status_out,
  input wire logic alert_out,
  input wire logic ramp_active_out,
  input wire logic output_enable_out,
  input wire logic [6:0] eff_rise_ms_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // timeout flag newly raised, and a read of a mapped code
  sequence s_trip;
    $rose(status_out.startup_timeout_flag);
  endsequence
  sequence s_rd(c);
    cmd_in.valid && !cmd_in.write && cmd_in.code == c && !loop_follower_in;
  endsequence
  chk_follower_nack: assert property (
    cmd_in.valid && loop_follower_in && cmd_in.code == STFS_CMD_LIMIT |=>
    rsp_out.nack && status_out.invalid_command_fault && alert_out)
    else $error("follower access not refused");
  chk_bad_retry: assert property (
    cmd_in.valid && cmd_in.write && cmd_in.code == STFS_CMD_RESPONSE &&
    !loop_follower_in && cmd_in.wdata[5:3] != 3'h0 && cmd_in.wdata[5:3] != 3'h7
    |=> rsp_out.nack && status_out.communication_fault_bit &&
    status_out.invalid_data && alert_out) else $error("bad retry accepted");
  chk_resp_read: assert property (
    s_rd(STFS_CMD_RESPONSE) |=> rsp_out.done && rsp_out.rdata[15:8] == 8'h00
    && !rsp_out.rdata[6] && rsp_out.rdata[2:0] == {3{rsp_out.rdata[5]}})
    else $error("response read malformed");
  chk_time_read: assert property (
    s_rd(STFS_CMD_RISE_TIME) or s_rd(STFS_CMD_LIMIT) |=> rsp_out.done &&
    !rsp_out.nack && rsp_out.rdata[15:7] == 9'h000)
    else $error("time register read malformed");
  chk_trip_flags: assert property (
    s_trip |-> status_out.other_fault && status_out.output_voltage_summary_bit
    && (alert_out || timeout_alert_mask_in)) else $error("trip flags missing");
  chk_trip_ramp: assert property (
    s_trip |-> $past(ramp_active_out)) else $error("trip outside ramp");
  chk_enable_ramp: assert property (
    ramp_active_out |-> output_enable_out) else $error("ramp without enable");
  chk_follower_rise: assert property (
    loop_follower_in [*4] |-> eff_rise_ms_out == STFS_LOOP_RISE_MS)
    else $error("follower rise time wrong");
endmodule
bind stfs_supervisor stfs_supervisor_checker u_chk (.clk_in, .rst_b_in,
  .cmd_in, .loop_follower_in, .timeout_alert_mask_in, .rsp_out, .status_out,
  .alert_out, .ramp_active_out, .output_enable_out, .eff_rise_ms_out);
`default_nettype wire

/* bench/stfs_host_model.sv */
// host model issuing configuration commands to the supervisor
`timescale 1ns/1ps
`default_nettype none
module stfs_host_model
  import stfs_pkg::*;
(
  input wire logic clk_in,
  output stfs_cmd_t cmd_out
);
  initial cmd_out = '0;
  // one command per call, lines scrambled once released
  task automatic issue(input logic w, input logic [7:0] c,
    input logic [15:0] d, input bit bad);
    logic [15:0] v;
    v = d;
    // retry field kept at 000 or 111 unless a refusal is wanted
    if (w && c == STFS_CMD_RESPONSE && !bad) v[4:3] = {2{d[5]}};
    @(posedge clk_in);
    cmd_out <= '{1'b1, w, c, v};
    @(posedge clk_in);
    cmd_out <= '{1'b0, ~w, ~c, ~v};
  endtask
endmodule
`default_nettype wire

/* bench/startup_timing_fault_supervisor_bench.sv */
// self-checking bench of the start-up timing supervisor
`timescale 1ns/1ps
`default_nettype none
module startup_timing_fault_supervisor_bench
  import stfs_pkg::*;
;
  logic clk_in = 0, rst_b_in = 0, lf = 0, pon = 0, tick = 0, uv = 0, mask = 0;
  logic [2:0] pl = 0;
  logic [1:0] tc = 0;
  stfs_cmd_t cmd_bus;
  stfs_rsp_t rsp;
  stfs_status_t st;
  logic alert, ramp, oen;
  logic [6:0] eff;
  logic [6:0] mt [10] = '{0, 1, 6, 7, 9, 10, 86, 87, 127, 0};
  stfs_rsp_t expq [$];
  int n_mismatch = 0, checks_done = 0, cyc = 0, t;
  stfs_host_model u_host (.clk_in(clk_in), .cmd_out(cmd_bus));
  stfs_supervisor u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .cmd_in(cmd_bus), .loop_follower_in(lf), .power_on_in(pon),
    .ms_tick_in(tick),
    .above_uv_in(uv), .timeout_alert_mask_in(mask), .clear_faults_in(pl[0]),
    .store_all_in(pl[1]), .restore_all_in(pl[2]), .rsp_out(rsp),
    .status_out(st), .alert_out(alert), .ramp_active_out(ramp),
    .output_enable_out(oen), .eff_rise_ms_out(eff));
  // clock and millisecond tick every fourth cycle
  initial forever #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    tc <= tc + 2'h1;
    tick <= (tc == 2'h0);
  end
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
    input logic n, input logic [15:0] r, input bit bad = 0);
    expq.push_back('{1'b1, n, r});
    u_host.issue(w, c, d, bad);
  endtask
  task pulse(input logic [2:0] v);
    @(posedge clk_in);
    pl <= v;
    @(posedge clk_in);
    pl <= 3'h0;
    repeat (2) @(posedge clk_in);
  endtask
  // k 0 waits for the timeout flag, 1 for the ramp; t counts ticks
  task await(input int k, output int n);
    n = 0;
    repeat (20000) begin
      @(posedge clk_in);
      if (tick) n++;
      if ((k == 0 ? st.startup_timeout_flag : ramp) === 1'b1) break;
    end
  endtask
  function automatic logic [6:0] qz(input logic [6:0] m);
    for (int i = 0; i < STFS_BUCKETS - 1; i++)
      if (m <= STFS_BOUND[i]) return STFS_EFFECT[i];
    return STFS_EFFECT[STFS_BUCKETS-1];
  endfunction
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // each answer compared with the oldest expectation
  always @(negedge clk_in) begin
    stfs_rsp_t e;
    if (rsp.done === 1'b1) begin
      e = expq.pop_front();
      check({rsp.nack, rsp.rdata}, {e.nack, e.rdata});
    end
  end
  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'h8bf7059f));
    mt[9] = 7'($urandom);
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1;
    repeat (3) @(posedge clk_in);
    cmd(0, STFS_CMD_RISE_TIME, 0, 0, 16'h0003);
    cmd(0, STFS_CMD_LIMIT, 0, 0, 16'h0000);
    cmd(0, STFS_CMD_RESPONSE, 0, 0, 16'h00bf);
    @(negedge clk_in);
    check(eff, 3);
    foreach (mt[i]) begin
      cmd(1, STFS_CMD_RISE_TIME, {9'h1ff, mt[i]}, 0, 0);
      cmd(0, STFS_CMD_RISE_TIME, 0, 0, {9'h000, mt[i]});
      repeat (4) @(negedge clk_in);
      check(eff, qz(mt[i]));
    end
    $display("test buckets done");
    cmd(1, STFS_CMD_RISE_TIME, 1, 0, 0);
    cmd(1, STFS_CMD_LIMIT, 5, 0, 0);
    pon <= 1;
    await(0, t);
    check(t >= 5 && t <= 6, 1);
    repeat (2) @(negedge clk_in);
    check({st.other_fault, st.output_voltage_summary_bit, alert}, 7);
    check({ramp, oen}, 0);
    await(1, t);
    check(t >= 7 && t <= 8, 1);
    pon <= 0;
    pulse(3'h1);
    $display("test retry done");
    cmd(1, STFS_CMD_RESPONSE, 16'h0080, 0, 0);
    pon <= 1;
    await(0, t);
    repeat (60) @(negedge clk_in);
    check(oen, 0);
    pulse(3'h1);
    await(1, t);
    check({st, alert, ramp}, 1);
    pon <= 0;
    pulse(3'h1);
    $display("test halt done");
    cmd(1, STFS_CMD_RESPONSE, 16'h0038, 0, 0);
    mask <= 1;
    pon <= 1;
    await(0, t);
    repeat (2) @(negedge clk_in);
    check({alert, oen}, 1);
    pon <= 0;
    mask <= 0;
    pulse(3'h1);
    cmd(1, STFS_CMD_LIMIT, 0, 0, 0);
    pon <= 1;
    repeat (800) @(negedge clk_in);
    check(st.startup_timeout_flag, 0);
    pon <= 0;
    // output reaches the threshold before a 5 ms limit: no trip, regulates
    cmd(1, STFS_CMD_LIMIT, 5, 0, 0);
    pon <= 1;
    repeat (8) @(negedge clk_in);
    uv <= 1;
    repeat (40) @(negedge clk_in);
    check({st.startup_timeout_flag, ramp, oen}, 1);
    pon <= 0;
    uv <= 0;
    $display("test ignore done");
    cmd(1, STFS_CMD_RISE_TIME, 100, 0, 0);
    cmd(1, STFS_CMD_LIMIT, 1, 0, 0);
    cmd(1, STFS_CMD_RESPONSE, 16'h0080, 0, 0);
    pon <= 1;
    await(0, t);
    check(t >= 4100 && t <= 4101, 1);
    pon <= 0;
    pulse(3'h1);
    $display("test short limit done");
    cmd(1, STFS_CMD_RISE_TIME, 1, 0, 0);
    cmd(1, STFS_CMD_RESPONSE, 16'h0028, 1, 0, 1);
    cmd(0, 8'h70, 0, 1, 0);
    repeat (2) @(negedge clk_in);
    check({st.communication_fault_bit, st.invalid_data, alert}, 7);
    pulse(3'h1);
    lf <= 1;
    cmd(0, STFS_CMD_LIMIT, 0, 1, 0);
    cmd(1, STFS_CMD_RESPONSE, 16'h00b8, 1, 0);
    repeat (4) @(negedge clk_in);
    check({st.invalid_command_fault, alert, eff}, {2'h3, 7'd100});
    lf <= 0;
    pulse(3'h1);
    cmd(0, STFS_CMD_RESPONSE, 0, 0, 16'h0080);
    pulse(3'h2);
    cmd(1, STFS_CMD_RESPONSE, 16'h00b8, 0, 0);
    pulse(3'h4);
    cmd(0, STFS_CMD_LIMIT, 0, 0, 0);
    cmd(0, STFS_CMD_RESPONSE, 0, 0, 16'h0080);
    repeat (3) @(negedge clk_in);
    check(expq.size(), 0);
    $display("test refusals and store done");
    conclude();
  end
endmodule
`default_nettype wire
